// *** include/art_map.vh ***
// Register map, field positions and constants of the reload timer
`ifndef ART_MAP_VH
`define ART_MAP_VH

// Word addresses on the Avalon-MM port (address is word index)
`define ART_ADDR_CTRL      4'h0
`define ART_ADDR_CNT_LO    4'h1
`define ART_ADDR_CNT_HI    4'h2
`define ART_ADDR_RLD_LO    4'h3
`define ART_ADDR_RLD_HI    4'h4
`define ART_ADDR_CLKCTL    4'h5
`define ART_ADDR_IRQEN     4'h6

// Counter control register fields
`define ART_CTRL_HOVF      7
`define ART_CTRL_LOVF      6
`define ART_CTRL_LIEN      5
`define ART_CTRL_CAPEN     4
`define ART_CTRL_SPLIT     3
`define ART_CTRL_RUN       2
`define ART_CTRL_XCLK      0

// Clock control register fields
`define ART_CLK_HFAST      5
`define ART_CLK_LFAST      4

// Interrupt enable register field
`define ART_IE_CNT         5

// Reset values and dividers
`define ART_BYTE_ZERO      8'h00
`define ART_BYTE_ONES      8'hff
`define ART_DIV12_LAST     4'hb
`define ART_DIV8_LAST      3'h7
`define ART_WORD_ZERO      32'h0000_0000

`endif

// *** hw/art_timer.v ***
// Auto-reload 16/8-bit timer with slow oscillator capture
`include "art_map.vh"
`timescale 1ns/10ps
`default_nettype none

module art_timer (
  input  wire        clk,
  input  wire        rstn,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output reg  [1:0]  avs_response,
  input  wire        ext_osc,
  input  wire        slow_osc,
  output wire        irq_request
);

  ////////////////////////////////////////////////////////////////////////
  // Register state
  reg [7:0] count_low_byte_reg;
  reg [7:0] count_high_byte_reg;
  reg [7:0] reload_low_byte_reg;
  reg [7:0] reload_high_byte_reg;
  reg       high_overflow_flag_reg;
  reg       low_overflow_flag_reg;
  reg       low_overflow_irq_enable_reg;
  reg       slow_osc_capture_enable_reg;
  reg       split_mode_select_reg;
  reg       high_byte_run_reg;
  reg       external_clock_select_reg;
  reg       high_byte_fast_clock_select_reg;
  reg       low_byte_fast_clock_select_reg;
  reg       counter_irq_enable_reg;
  reg       ack_reg;

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers and tick generation
  reg [1:0] ext_sync_reg;
  reg       ext_last_reg;
  reg [2:0] ext_div_reg;
  reg [1:0] slow_sync_reg;
  reg       slow_last_reg;
  reg [3:0] div12_reg;

  wire ext_rise;
  wire ext_tick;
  wire div12_tick;
  wire slow_fall;

  // two-stage synchroniser, edge seen after second stage
  always @(posedge clk) begin
    if (!rstn) begin
      ext_sync_reg  <= 2'h0;
      ext_last_reg  <= 1'h0;
      slow_sync_reg <= 2'h0;
      slow_last_reg <= 1'h0;
    end else begin
      ext_sync_reg  <= {ext_sync_reg[0], ext_osc};
      ext_last_reg  <= ext_sync_reg[1];
      slow_sync_reg <= {slow_sync_reg[0], slow_osc};
      slow_last_reg <= slow_sync_reg[1];
    end
  end

  assign ext_rise = ext_sync_reg[1] & ~ext_last_reg;
  assign slow_fall = ~slow_sync_reg[1] & slow_last_reg;

  // free-running dividers for the slow sources
  always @(posedge clk) begin
    if (!rstn) begin
      div12_reg   <= 4'h0;
      ext_div_reg <= 3'h0;
    end else begin
      if (div12_reg == `ART_DIV12_LAST)
        div12_reg <= 4'h0;
      else
        div12_reg <= div12_reg + 4'h1;
      if (ext_rise)
        ext_div_reg <= ext_div_reg + 3'h1;
    end
  end

  assign div12_tick = (div12_reg == `ART_DIV12_LAST);
  assign ext_tick   = ext_rise & (ext_div_reg == `ART_DIV8_LAST);

  ////////////////////////////////////////////////////////////////////////
  // Per-byte clock selection
  wire slow_src;
  wire low_tick;
  wire high_tick;

  // fast select wins, else external bit picks divider
  assign slow_src  = external_clock_select_reg ? ext_tick : div12_tick;
  assign low_tick  = low_byte_fast_clock_select_reg ? 1'b1 : slow_src;
  assign high_tick = high_byte_fast_clock_select_reg ? 1'b1 : slow_src;

  ////////////////////////////////////////////////////////////////////////
  // Counting engine
  reg  [7:0] cnt_lo_next;
  reg  [7:0] cnt_hi_next;
  reg        set_hovf;
  reg        set_lovf;
  reg        capture;
  wire       low_en;
  wire       low_wrap;
  wire       high_wrap16;
  wire       high_wrap8;

  // low byte always runs in split mode
  assign low_en = split_mode_select_reg ? low_tick
                                        : (low_tick & high_byte_run_reg);
  assign low_wrap    = low_en & (count_low_byte_reg == `ART_BYTE_ONES);
  assign high_wrap16 = low_wrap & (count_high_byte_reg == `ART_BYTE_ONES);
  assign high_wrap8  = high_tick & high_byte_run_reg &
                       (count_high_byte_reg == `ART_BYTE_ONES);

  // Next count, reload and flag events for the present mode
  always @* begin
    cnt_lo_next = count_low_byte_reg;
    cnt_hi_next = count_high_byte_reg;
    set_hovf    = 1'b0;
    set_lovf    = 1'b0;
    // in 16-bit mode, capture enable replaces the reload on wrap
    capture     = slow_osc_capture_enable_reg & slow_fall;
    if (split_mode_select_reg) begin
      // each byte reloads from its own register
      if (low_en)
        cnt_lo_next = low_wrap ? reload_low_byte_reg
                               : count_low_byte_reg + 8'h01;
      if (high_tick & high_byte_run_reg)
        cnt_hi_next = high_wrap8 ? reload_high_byte_reg
                                 : count_high_byte_reg + 8'h01;
      // each byte wrap sets its flag
      set_lovf = low_wrap;
      set_hovf = high_wrap8;
    end else begin
      // low carry advances the high byte
      if (low_en) begin
        cnt_lo_next = count_low_byte_reg + 8'h01;
        if (low_wrap)
          cnt_hi_next = count_high_byte_reg + 8'h01;
      end
      // full wrap reloads the pair, sets high flag
      if (high_wrap16 & ~slow_osc_capture_enable_reg) begin
        cnt_lo_next = reload_low_byte_reg;
        cnt_hi_next = reload_high_byte_reg;
      end
      set_lovf = low_wrap;
      set_hovf = high_wrap16 & ~slow_osc_capture_enable_reg;
    end
    // falling edge captures and sets high flag
    if (capture)
      set_hovf = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire       wr_hit;
  wire       acc;
  wire       be0;
  wire [7:0] wd;

  assign acc    = (avs_read | avs_write) & ~ack_reg;
  // Write lands at the edge where waitrequest is sampled low
  assign wr_hit = avs_write & ack_reg;
  assign be0    = avs_byteenable[0];
  assign wd     = avs_writedata[7:0];
  // One wait cycle, answer on the second edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

  // Registers: hardware updates, software writes win on data fields
  always @(posedge clk) begin
    if (!rstn) begin
      count_low_byte_reg              <= `ART_BYTE_ZERO;
      count_high_byte_reg             <= `ART_BYTE_ZERO;
      reload_low_byte_reg             <= `ART_BYTE_ZERO;
      reload_high_byte_reg            <= `ART_BYTE_ZERO;
      high_overflow_flag_reg          <= 1'b0;
      low_overflow_flag_reg           <= 1'b0;
      low_overflow_irq_enable_reg     <= 1'b0;
      slow_osc_capture_enable_reg     <= 1'b0;
      split_mode_select_reg           <= 1'b0;
      high_byte_run_reg               <= 1'b0;
      external_clock_select_reg       <= 1'b0;
      high_byte_fast_clock_select_reg <= 1'b0;
      low_byte_fast_clock_select_reg  <= 1'b0;
      counter_irq_enable_reg          <= 1'b0;
      ack_reg                         <= 1'b0;
    end else begin
      ack_reg              <= acc;
      count_low_byte_reg   <= cnt_lo_next;
      count_high_byte_reg  <= cnt_hi_next;
      if (capture) begin
        reload_low_byte_reg  <= count_low_byte_reg;
        reload_high_byte_reg <= count_high_byte_reg;
      end
      if (wr_hit & be0) begin
        case (avs_address)
          `ART_ADDR_CNT_LO: count_low_byte_reg   <= wd;
          `ART_ADDR_CNT_HI: count_high_byte_reg  <= wd;
          `ART_ADDR_RLD_LO: reload_low_byte_reg  <= wd;
          `ART_ADDR_RLD_HI: reload_high_byte_reg <= wd;
          `ART_ADDR_CTRL: begin
            low_overflow_irq_enable_reg <= wd[`ART_CTRL_LIEN];
            slow_osc_capture_enable_reg <= wd[`ART_CTRL_CAPEN];
            // software keeps this clear while capturing
            split_mode_select_reg       <= wd[`ART_CTRL_SPLIT];
            high_byte_run_reg           <= wd[`ART_CTRL_RUN];
            external_clock_select_reg   <= wd[`ART_CTRL_XCLK];
          end
          `ART_ADDR_CLKCTL: begin
            high_byte_fast_clock_select_reg <= wd[`ART_CLK_HFAST];
            low_byte_fast_clock_select_reg  <= wd[`ART_CLK_LFAST];
          end
          `ART_ADDR_IRQEN: counter_irq_enable_reg <= wd[`ART_IE_CNT];
          default: ;
        endcase
      end
      // only software clears; a new event wins
      if (wr_hit & be0 & (avs_address == `ART_ADDR_CTRL)) begin
        high_overflow_flag_reg <= wd[`ART_CTRL_HOVF] | set_hovf;
        low_overflow_flag_reg  <= wd[`ART_CTRL_LOVF] | set_lovf;
      end else begin
        high_overflow_flag_reg <= high_overflow_flag_reg | set_hovf;
        low_overflow_flag_reg  <= low_overflow_flag_reg | set_lovf;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data and response
  reg [7:0] rd_byte;
  reg       rd_ok;

  // Read mux; unused control bit reads zero
  always @* begin
    rd_byte = `ART_BYTE_ZERO;
    rd_ok   = 1'b1;
    case (avs_address)
      `ART_ADDR_CTRL: begin
        rd_byte[`ART_CTRL_HOVF]  = high_overflow_flag_reg;
        rd_byte[`ART_CTRL_LOVF]  = low_overflow_flag_reg;
        rd_byte[`ART_CTRL_LIEN]  = low_overflow_irq_enable_reg;
        rd_byte[`ART_CTRL_CAPEN] = slow_osc_capture_enable_reg;
        rd_byte[`ART_CTRL_SPLIT] = split_mode_select_reg;
        rd_byte[`ART_CTRL_RUN]   = high_byte_run_reg;
        rd_byte[`ART_CTRL_XCLK]  = external_clock_select_reg;
      end
      `ART_ADDR_CNT_LO: rd_byte = count_low_byte_reg;
      `ART_ADDR_CNT_HI: rd_byte = count_high_byte_reg;
      `ART_ADDR_RLD_LO: rd_byte = reload_low_byte_reg;
      `ART_ADDR_RLD_HI: rd_byte = reload_high_byte_reg;
      `ART_ADDR_CLKCTL: begin
        rd_byte[`ART_CLK_HFAST] = high_byte_fast_clock_select_reg;
        rd_byte[`ART_CLK_LFAST] = low_byte_fast_clock_select_reg;
      end
      `ART_ADDR_IRQEN: rd_byte[`ART_IE_CNT] = counter_irq_enable_reg;
      default: rd_ok = 1'b0;
    endcase
  end

  // Registered read data so it stands at the answering edge
  always @(posedge clk) begin
    if (!rstn) begin
      avs_readdata <= `ART_WORD_ZERO;
      avs_response <= 2'h0;
    end else if (acc) begin
      avs_readdata <= {24'h000000, rd_byte};
      avs_response <= rd_ok ? 2'h0 : 2'h3;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt request to the processor
  // high overflow with counter enable
  // low overflow adds when low enable set
  // level stays until software clears flags or enables
  assign irq_request = counter_irq_enable_reg &
                       (high_overflow_flag_reg |
                        (low_overflow_irq_enable_reg &
                         low_overflow_flag_reg));

endmodule // art_timer

`default_nettype wire

// *** dv/art_timer_sva.sv ***
// Port assertions for the reload timer, bound into art_timer
`timescale 1ns/10ps
`default_nettype none
module art_timer_chk (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  input wire logic        irq_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic ie_sh;
  logic busy;
  ////////////////////////////////////////////////////////////////////////////
  // Enable shadow takes completed writes; a write in flight is exempt
  always @(posedge clk) begin
    if (!rstn)
      ie_sh <= 1'h0;
    else if (avs_write && !avs_waitrequest && avs_address == 4'h6)
      ie_sh <= avs_writedata[5];
  end
  assign busy = avs_read | avs_write;
  ////////////////////////////////////////////////////////////////////////////
  chk_rd_wait:
    assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait");
  chk_wr_wait:
    assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("write not answered after one wait");
  chk_rd_upper:
    assert property (avs_read && !avs_waitrequest
      |-> avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
  chk_unmapped:
    assert property (busy && !avs_waitrequest && avs_address > 4'h6
      |-> avs_response == 2'h3 && avs_readdata == 32'h0)
    else $error("unmapped access not refused");
  chk_resp_ok:
    assert property (busy && !avs_waitrequest && avs_address <= 4'h6
      |-> avs_response == 2'h0) else $error("mapped access refused");
  chk_rd_hold:
    assert property (!busy && !$past(busy) |-> $stable(avs_readdata))
    else $error("read data moved while idle");
  chk_irq_hold:
    assert property ($fell(irq_request) |-> $past(avs_write)
      && ($past(avs_address) == 4'h0 || $past(avs_address) == 4'h6))
    else $error("interrupt dropped without a software write");
  chk_irq_gate:
    assert property (irq_request && !avs_write |-> ie_sh)
    else $error("interrupt while counter irq disabled");
endmodule // art_timer_chk
bind art_timer art_timer_chk u_chk (.clk(clk), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .irq_request(irq_request));
`default_nettype wire

// *** dv/test_art_timer.sv ***
// Self-checking bench for the reload timer
`timescale 1ns/10ps
`default_nettype none
`include "art_map.vh"
module test_art_timer;
  logic        clk = 1'h0;
  logic        rstn = 1'h0;
  logic [3:0]  adr = 4'h0;
  logic        rde = 1'h0;
  logic        wre = 1'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  be = 4'h1;
  logic [31:0] rdat;
  logic        wreq;
  logic [1:0]  resp;
  logic        ext_osc = 1'h0;
  logic        slow_osc = 1'h1;
  logic        irq;
  logic [7:0]  rd;
  logic [7:0]  msk [0:6] = '{8'hf1, 8'hff, 8'hff, 8'hff, 8'hff, 8'h30, 8'h20};
  int          mdl [0:6] = '{default: 0};
  int          bad_count = 0;
  int          tests_run = 0;
  ////////////////////////////////////////////////////////////////////////////
  // System clock and an unrelated external oscillator
  always #5 clk = ~clk;
  always #37 ext_osc = ~ext_osc;
  art_timer dut (.clk(clk), .rstn(rstn), .avs_address(adr), .avs_read(rde),
    .avs_write(wre), .avs_writedata(wdat), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .avs_response(resp),
    .ext_osc(ext_osc), .slow_osc(slow_osc), .irq_request(irq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bus cycle: request held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wdat <= {24'h0, d};
    wre <= w;
    rde <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'h0 && n < 9);
    rd = rdat[7:0];
    wre <= 1'h0;
    rde <= 1'h0;
    // Let the answering edge's updates settle before anyone samples
    @(posedge clk);
    if (n >= 9) begin
      bad_count++;
      results();
    end
  endtask
  // Bounded wait for the interrupt line
  task automatic wirq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'h1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      bad_count++;
      results();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    acc(1'h1, a, d);
    if (a < 4'h7 && be[0])
      mdl[a] = d;
  endtask
  task automatic rdc(input logic [3:0] a);
    acc(1'h0, a, 8'h00);
    chk(rd, mdl[a]);
  endtask
  // Counts move while running, so they are judged against a window
  task automatic rng(input logic [3:0] a, input int lo, input int hi);
    acc(1'h0, a, 8'h00);
    chk(rd >= lo && rd <= hi, 1'h1);
  endtask
  task automatic cx(input logic [7:0] e);
    mdl[0] = e;
    rdc(`ART_ADDR_CTRL);
  endtask
  task automatic ld(input logic [7:0] cl, ch, rl, rh, ck);
    wr(`ART_ADDR_CNT_LO, cl);
    wr(`ART_ADDR_CNT_HI, ch);
    wr(`ART_ADDR_RLD_LO, rl);
    wr(`ART_ADDR_RLD_HI, rh);
    wr(`ART_ADDR_CLKCTL, ck);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(61));
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    for (int a = 0; a < 8; a++) begin
      acc(1'h0, a[3:0], 8'h00);
      chk(rd, 8'h00);
      chk(resp, a == 7 ? 2'h3 : 2'h0);
    end
    for (int a = 0; a < 8; a++)
      wr(a[3:0], 8'($urandom) & msk[a % 7]);
    be <= 4'h0;
    wr(`ART_ADDR_CNT_LO, 8'ha5);
    be <= 4'h1;
    for (int a = 0; a < 7; a++)
      rdc(a[3:0]);
    wr(`ART_ADDR_CTRL, 8'h00);
    // Rate of each clock source, counter stopped before reading
    for (int k = 0; k < 3; k++) begin
      ld(8'h00, 8'h00, 8'h00, 8'h00, k == 0 ? 8'h10 : 8'h00);
      wr(`ART_ADDR_CTRL, k == 2 ? 8'h05 : 8'h04);
      repeat (k == 0 ? 50 : k == 1 ? 600 : 2960) @(posedge clk);
      wr(`ART_ADDR_CTRL, 8'h00);
      rng(`ART_ADDR_CNT_LO, 47, 56);
      rng(`ART_ADDR_CNT_HI, 0, 0);
    end
    // Full wrap reloads the pair; low wrap adds interrupt with enable
    ld(8'hf8, 8'hff, 8'h34, 8'h12, 8'h10);
    wr(`ART_ADDR_IRQEN, 8'h20);
    chk(irq, 1'h0);
    wr(`ART_ADDR_CTRL, 8'h04);
    wirq(60);
    cx(8'hc4);
    rdc(`ART_ADDR_RLD_LO);
    rng(`ART_ADDR_CNT_HI, 8'h12, 8'h12);
    repeat (40) @(posedge clk);
    chk(irq, 1'h1);
    wr(`ART_ADDR_CTRL, 8'h24);
    chk(irq, 1'h0);
    wirq(300);
    cx(8'h64);
    // Split mode: own reloads, run gates the high byte only
    wr(`ART_ADDR_CTRL, 8'h00);
    ld(8'hfe, 8'hf0, 8'h40, 8'h80, 8'h30);
    wr(`ART_ADDR_CTRL, 8'h08);
    repeat (30) @(posedge clk);
    cx(8'h48);
    chk(irq, 1'h0);
    rng(`ART_ADDR_CNT_HI, 8'hf0, 8'hf0);
    rng(`ART_ADDR_CNT_LO, 8'h40, 8'h70);
    wr(`ART_ADDR_CTRL, 8'h4c);
    repeat (30) @(posedge clk);
    cx(8'hcc);
    chk(irq, 1'h1);
    rng(`ART_ADDR_CNT_HI, 8'h80, 8'ha0);
    wr(`ART_ADDR_CTRL, 8'h08);
    repeat (300) @(posedge clk);
    cx(8'h48);
    chk(irq, 1'h0);
    // Capture on a slow oscillator fall, none on its rise
    wr(`ART_ADDR_CTRL, 8'h00);
    ld(8'h00, 8'h00, 8'h00, 8'h00, 8'h10);
    wr(`ART_ADDR_CTRL, 8'h14);
    repeat (20) @(posedge clk);
    slow_osc <= 1'h0;
    wirq(20);
    rng(`ART_ADDR_RLD_LO, 20, 34);
    rng(`ART_ADDR_RLD_HI, 0, 0);
    slow_osc <= 1'h1;
    wr(`ART_ADDR_CTRL, 8'h14);
    repeat (20) @(posedge clk);
    chk(irq, 1'h0);
    results();
  end
endmodule // test_art_timer
`default_nettype wire
